//--- hdl/smct_cnt_if.sv
// Interface between the access sequencer and its phase counter
`timescale 1ns/100ps
`default_nettype none
interface smct_cnt_if #(
  parameter int unsigned CNT_W = 6
);
  logic load;               // Start a new phase
  logic [CNT_W-1:0] len_m1; // Phase length minus one
  logic last;               // Current cycle is the final one of the phase

  modport ctrl (output load, output len_m1, input last);
  modport cnt (input load, input len_m1, output last);
endinterface
`default_nettype wire

//--- hdl/smct_ctrl.sv
// Static external memory access sequencer with programmable phase lengths
`timescale 1ns/100ps
`default_nettype none
module smct_ctrl
  import smct_pkg::*;
#(
  parameter int unsigned WAIT_W = SMCT_WAIT_W,
  parameter int unsigned ADDR_W = SMCT_ADDR_W,
  parameter int unsigned DATA_W = SMCT_DATA_W
)(
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Wait settings, from logic on this clock
  input wire logic [WAIT_W-1:0] oe_delay_cycles_i,
  input wire logic [WAIT_W-1:0] read_length_cycles_i,
  input wire logic [WAIT_W-1:0] we_delay_cycles_i,
  input wire logic [WAIT_W-1:0] write_length_cycles_i,
  input wire logic [SMCT_CFG_W-1:0] read_delay_config_i,
  // Access request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [DATA_W/8-1:0] req_lanes_i,
  // Access completion
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  // Memory pins
  output logic cs_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [DATA_W/8-1:0] byte_lane_select_n_o,
  output logic [ADDR_W-1:0] addr_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o
);

  localparam int unsigned CNT_W = WAIT_W + 2; // Room for sums without wrap
  localparam int unsigned LANES = DATA_W / 8;

  // Refuse shapes the lane logic cannot serve
  if (WAIT_W < 1 || ADDR_W < 1 || DATA_W < 8 || (DATA_W % 8) != 0)
  begin : g_check
    $error("smct_ctrl: unsupported width parameters");
  end

  // Saturating difference a - b, zero when b exceeds a
  function automatic logic [CNT_W-1:0] sat_sub(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    logic [CNT_W-1:0] r;
    r = (a > b) ? (a - b) : '0;
    return r;
  endfunction

  smct_state_e state_q; // Sequencer state
  smct_state_e state_d;
  logic wr_q; // Access in flight is a write
  logic [ADDR_W-1:0] addr_q; // Latched address
  logic [DATA_W-1:0] wdata_q; // Latched write data
  logic [LANES-1:0] lanes_q; // Latched lane enables, active high
  logic [CNT_W-1:0] strobe_m1_q; // Strobe phase length minus one
  logic [DATA_W-1:0] din_meta_q; // First sampling stage of the data pins
  logic [DATA_W-1:0] din_q; // Second sampling stage, the only one read
  logic rsp_valid_q; // Completion pulse
  logic [DATA_W-1:0] rdata_q; // Captured read data
  logic cs_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic bls_n_q;
  logic data_oe_q;

  // Settings widened so that sums and differences never wrap
  logic [CNT_W-1:0] oed_w;
  logic [CNT_W-1:0] rdl_w;
  logic [CNT_W-1:0] wed_w;
  logic [CNT_W-1:0] wrl_w;
  logic [CNT_W-1:0] rd_adj_w; // One when the read delay adjust bit is set
  logic [CNT_W-1:0] rd_delay; // Chip select to output enable, in cycles
  logic [CNT_W-1:0] rd_width; // Output enable pulse, in cycles
  logic [CNT_W-1:0] wr_eff; // Write length, never below the enable delay

  assign oed_w = CNT_W'(oe_delay_cycles_i);
  assign rdl_w = CNT_W'(read_length_cycles_i);
  assign wed_w = CNT_W'(we_delay_cycles_i);
  assign wrl_w = CNT_W'(write_length_cycles_i);
  assign rd_adj_w = CNT_W'(read_delay_config_i[SMCT_RD_ADJ_BIT]);

  // Read phase lengths from the settings
  always_comb
  begin
    if (rdl_w < oed_w)
    begin
      // Short read: strobes move with chip select, single cycle pulse
      rd_delay = '0;
      rd_width = CNT_W'(1);
    end
    else
    begin
      // Adjust bit moves the edge later and shortens the pulse
      rd_delay = oed_w + rd_adj_w;
      if (rd_delay > rdl_w)
      begin
        rd_delay = rdl_w;
      end
      rd_width = sat_sub(rdl_w + CNT_W'(1), oed_w + rd_adj_w);
      if (rd_width == '0)
      begin
        rd_width = CNT_W'(1);
      end
    end
  end

  // Write length below the enable delay is raised to it, which keeps
  // the enable pulse at one cycle and the lane pulse at three
  assign wr_eff = (wrl_w < wed_w) ? wed_w : wrl_w;

  smct_cnt_if #(.CNT_W(CNT_W)) cnt_if ();

  smct_phase_cnt #(
    .CNT_W(CNT_W)
  ) u_phase_cnt (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cnt_if(cnt_if)
  );

  // Next state and phase counter loads
  always_comb
  begin
    state_d = state_q;
    cnt_if.load = 1'b0;
    cnt_if.len_m1 = '0;
    case (state_q)
      SMCT_IDLE:
      begin
        if (req_valid_i && req_write_i)
        begin
          // Lanes wait the enable delay; none means lanes with chip select
          cnt_if.load = 1'b1;
          cnt_if.len_m1 = sat_sub(wed_w, CNT_W'(1));
          state_d = (wed_w == '0) ? SMCT_WR_BLS : SMCT_WR_SETUP;
        end
        else if (req_valid_i)
        begin
          // Address goes out with chip select, strobes after the delay
          cnt_if.load = 1'b1;
          cnt_if.len_m1 = (rd_delay == '0) ? sat_sub(rd_width, CNT_W'(1))
                                           : sat_sub(rd_delay, CNT_W'(1));
          state_d = (rd_delay == '0) ? SMCT_RD_STROBE : SMCT_RD_SETUP;
        end
      end
      SMCT_RD_SETUP:
      begin
        if (cnt_if.last)
        begin
          cnt_if.load = 1'b1;
          cnt_if.len_m1 = strobe_m1_q;
          state_d = SMCT_RD_STROBE;
        end
      end
      SMCT_RD_STROBE:
      begin
        if (cnt_if.last)
        begin
          state_d = SMCT_HOLD;
        end
      end
      SMCT_WR_SETUP:
      begin
        if (cnt_if.last)
        begin
          state_d = SMCT_WR_BLS;
        end
      end
      SMCT_WR_BLS:
      begin
        // Write enable follows the lanes by one cycle
        cnt_if.load = 1'b1;
        cnt_if.len_m1 = strobe_m1_q;
        state_d = SMCT_WR_STROBE;
      end
      SMCT_WR_STROBE:
      begin
        if (cnt_if.last)
        begin
          state_d = SMCT_WR_TAIL;
        end
      end
      SMCT_WR_TAIL:
      begin
        // Lanes outlast write enable by one cycle, address and data stay
        state_d = SMCT_HOLD;
      end
      SMCT_HOLD:
      begin
        // Chip select high, address still out for one cycle
        state_d = wr_q ? SMCT_IDLE : SMCT_RD_FETCH;
      end
      SMCT_RD_FETCH:
      begin
        state_d = SMCT_IDLE;
      end
      default:
      begin
        state_d = SMCT_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SMCT_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Request capture; settings are frozen for the whole access
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      lanes_q <= '0;
      strobe_m1_q <= '0;
    end
    else if (state_q == SMCT_IDLE && req_valid_i)
    begin
      wr_q <= req_write_i;
      addr_q <= req_addr_i;
      wdata_q <= req_wdata_i;
      lanes_q <= req_lanes_i;
      // Write enable pulse is write length minus delay plus one
      strobe_m1_q <= req_write_i ? (wr_eff - wed_w) : sat_sub(rd_width, CNT_W'(1));
    end
  end

  // Pin levels registered from the next state, so pins move with state_q
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cs_n_q <= SMCT_STROBE_IDLE;
      oe_n_q <= SMCT_STROBE_IDLE;
      we_n_q <= SMCT_STROBE_IDLE;
      bls_n_q <= SMCT_STROBE_IDLE;
      data_oe_q <= 1'b0;
    end
    else
    begin
      cs_n_q <= !(state_d inside {SMCT_RD_SETUP, SMCT_RD_STROBE, SMCT_WR_SETUP,
                                  SMCT_WR_BLS, SMCT_WR_STROBE, SMCT_WR_TAIL});
      oe_n_q <= (state_d != SMCT_RD_STROBE);
      we_n_q <= (state_d != SMCT_WR_STROBE);
      bls_n_q <= !(state_d inside {SMCT_RD_STROBE, SMCT_WR_BLS, SMCT_WR_STROBE,
                                   SMCT_WR_TAIL});
      // Write data from chip select until one cycle after the lanes rise
      data_oe_q <= (state_d inside {SMCT_WR_SETUP, SMCT_WR_BLS, SMCT_WR_STROBE,
                                    SMCT_WR_TAIL})
                   || (state_d == SMCT_HOLD && wr_q);
    end
  end

  // Data pins pass two stages; the first feeds only the second
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      din_meta_q <= '0;
      din_q <= '0;
    end
    else
    begin
      din_meta_q <= data_i;
      din_q <= din_meta_q;
    end
  end

  // Completion; the read word is the pin value at the edge that ends the
  // strobe, which reaches the second stage one cycle later
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      rsp_valid_q <= (state_q == SMCT_RD_FETCH) || (state_q == SMCT_HOLD && wr_q);
      if (state_q == SMCT_RD_FETCH)
      begin
        rdata_q <= din_q;
      end
    end
  end

  // A new access is taken only from idle
  assign req_ready_o = (state_q == SMCT_IDLE);
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_rdata_o = rdata_q;
  assign cs_n_o = cs_n_q;
  assign oe_n_o = oe_n_q;
  assign we_n_o = we_n_q;
  // Only the requested lanes go low; the rest stay high throughout
  assign byte_lane_select_n_o = bls_n_q ? {LANES{1'b1}} : ~lanes_q;
  assign addr_o = addr_q;
  assign data_o = wdata_q;
  assign data_oe_o = data_oe_q;

endmodule
`default_nettype wire

//--- hdl/smct_phase_cnt.sv
// Down counter that times one phase of an external memory access
`timescale 1ns/100ps
`default_nettype none
module smct_phase_cnt
  import smct_pkg::*;
#(
  parameter int unsigned CNT_W = 6
)(
  input wire logic clock_i,
  input wire logic rst_n_i,
  smct_cnt_if.cnt cnt_if
);

  logic [CNT_W-1:0] cnt_q; // Cycles left after the present one

  // A counter needs at least one bit to time even a one-cycle phase
  if (CNT_W < 1)
  begin : g_check
    $error("smct_phase_cnt: counter width must be at least one");
  end

  // Load on phase entry, else count toward zero and park there
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else if (cnt_if.load)
    begin
      cnt_q <= cnt_if.len_m1;
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // A loaded zero makes the very next cycle the last one
  assign cnt_if.last = (cnt_q == '0);

endmodule
`default_nettype wire

//--- hdl/smct_pkg.sv
// Package for the static memory cycle timing block: constants and states
package smct_pkg;

  // Default widths of the settings and the memory side
  localparam int unsigned SMCT_WAIT_W = 4;
  localparam int unsigned SMCT_ADDR_W = 24;
  localparam int unsigned SMCT_DATA_W = 16;
  localparam int unsigned SMCT_CFG_W = 8;

  // Position of the read delay adjust bit in the read delay configuration
  localparam int unsigned SMCT_RD_ADJ_BIT = 5;

  // Fixed phase lengths in bus clock cycles
  localparam int unsigned SMCT_HOLD_CYCLES = 1;
  localparam int unsigned SMCT_WR_TAIL_CYCLES = 1;

  // Inactive level of every active-low strobe
  localparam logic SMCT_STROBE_IDLE = 1'b1;

  // Access sequencer states, one-hot
  typedef enum logic [8:0] {
    SMCT_IDLE      = 9'h001,
    SMCT_RD_SETUP  = 9'h002,
    SMCT_RD_STROBE = 9'h004,
    SMCT_RD_FETCH  = 9'h008,
    SMCT_WR_SETUP  = 9'h010,
    SMCT_WR_BLS    = 9'h020,
    SMCT_WR_STROBE = 9'h040,
    SMCT_WR_TAIL   = 9'h080,
    SMCT_HOLD      = 9'h100
  } smct_state_e;

endpackage

//--- tb/smct_ctrl_assertions.sv
// Pin timing checker for the static memory sequencer
`timescale 1ns/100ps
`default_nettype none
module smct_ctrl_assertions
  import smct_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] oe_delay_cycles_i,
  input wire logic [3:0] read_length_cycles_i,
  input wire logic [3:0] we_delay_cycles_i,
  input wire logic [3:0] write_length_cycles_i,
  input wire logic [7:0] read_delay_config_i,
  input wire logic req_ready_o,
  input wire logic cs_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic [1:0] byte_lane_select_n_o,
  input wire logic [23:0] addr_o,
  input wire logic [15:0] data_o,
  input wire logic data_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  int o, r, e, b, d, w, s; // Settings and expected phases
  int c_cs, c_oe, c_we, c_ln; // Low run of each strobe
  logic lane_low; // Some byte lane selected
  assign lane_low = byte_lane_select_n_o != 2'h3;
  // Live settings; valid because the bench holds them over an access
  always_comb
  begin
    o = int'(oe_delay_cycles_i);
    r = int'(read_length_cycles_i);
    e = int'(we_delay_cycles_i);
    b = int'(read_delay_config_i[SMCT_RD_ADJ_BIT]);
    d = r < o ? 0 : (o + b > r ? r : o + b);
    w = r < o || r < o + b ? 1 : r - o + 1 - b;
    s = (int'(write_length_cycles_i) < e ? e : int'(write_length_cycles_i)) - e + 1;
  end
  // Run counters, cleared in reset so no stale run leaks in
  always_ff @(posedge clock_i)
  begin
    c_cs <= !rst_n_i || cs_n_o ? 0 : c_cs + 1;
    c_oe <= !rst_n_i || oe_n_o ? 0 : c_oe + 1;
    c_we <= !rst_n_i || we_n_o ? 0 : c_we + 1;
    c_ln <= !rst_n_i || !lane_low ? 0 : c_ln + 1;
  end
  // Write data and address still driven and unchanged
  sequence s_wtail;
    data_oe_o && $stable(data_o) && $stable(addr_o);
  endsequence
  chk_idle_quiet: assert property (req_ready_o |-> cs_n_o && oe_n_o && we_n_o
    && !lane_low && !data_oe_o) else $error("strobe active in idle");
  chk_oe_delay: assert property ($fell(oe_n_o) |-> c_cs == d)
    else $error("oe delay wrong");
  chk_rd_lane_dly: assert property ($rose(lane_low) && !data_oe_o |-> c_cs == d)
    else $error("read lane delay wrong");
  chk_oe_width: assert property ($rose(oe_n_o) |-> c_oe == w && $rose(cs_n_o)
    && !lane_low) else $error("oe width wrong");
  chk_rd_lane_w: assert property ($fell(lane_low) && !data_oe_o |-> c_ln == w)
    else $error("read lane width wrong");
  chk_addr_hold: assert property ($rose(cs_n_o) |=> $stable(addr_o))
    else $error("address not held");
  chk_we_delay: assert property ($fell(we_n_o) |-> c_cs == e + 1 && c_ln == 1
    && data_oe_o) else $error("we delay wrong");
  chk_we_width: assert property ($rose(we_n_o) |-> c_we == s)
    else $error("we width wrong");
  chk_wr_hold: assert property ($rose(we_n_o) |-> s_wtail ##1 s_wtail)
    else $error("write hold wrong");
  chk_wr_lane_w: assert property ($fell(lane_low) && data_oe_o |-> c_ln == s + 2
    ##0 s_wtail) else $error("write lane width wrong");
endmodule
`default_nettype wire

//--- tb/smct_sram_model.sv
// Behavioural asynchronous static memory on the sequencer pins
`timescale 1ns/100ps
`default_nettype none
module smct_sram_model
(
  input wire logic clock_i,
  input wire logic slow_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [1:0] bls_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [16]; // Few words suffice
  logic [15:0] last_q = 16'h0; // Last shown value
  logic rd_q = 1'b0; // Read seen last edge
  logic rd; // Selected and enabled
  assign rd = !cs_n_i && !oe_n_i;
  // Released bus flips each cycle; a slow part misses the first cycle
  assign rdata_o = rd && (!slow_i || rd_q) ? mem[addr_i] : ~last_q;
  // Selected bytes land while the write strobe is low
  always @(posedge clock_i)
  begin
    last_q <= rdata_o;
    rd_q <= rd;
    if (!cs_n_i && !we_n_i && !bls_n_i[0])
      mem[addr_i][7:0] <= wdata_i[7:0];
    if (!cs_n_i && !we_n_i && !bls_n_i[1])
      mem[addr_i][15:8] <= wdata_i[15:8];
  end
endmodule
`default_nettype wire

//--- tb/tb_static_memory_cycle_timing.sv
// Self-checking bench for the static memory sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_static_memory_cycle_timing;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slow = 1'b0; // Memory answers late
  logic req_valid_i, req_ready_o, req_write_i, rsp_valid_o, cs_n_o, oe_n_o, we_n_o, data_oe_o;
  logic [3:0] oe_delay_cycles_i, read_length_cycles_i, we_delay_cycles_i, write_length_cycles_i;
  logic [7:0] read_delay_config_i;
  logic [23:0] req_addr_i, addr_o;
  logic [15:0] req_wdata_i, rsp_rdata_o, data_i, data_o;
  logic [1:0] req_lanes_i, byte_lane_select_n_o;
  int n_mismatch, n_compared, n_cyc;
  smct_ctrl i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .oe_delay_cycles_i(oe_delay_cycles_i),
    .read_length_cycles_i(read_length_cycles_i), .we_delay_cycles_i(we_delay_cycles_i),
    .write_length_cycles_i(write_length_cycles_i), .read_delay_config_i(read_delay_config_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_lanes_i(req_lanes_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .cs_n_o(cs_n_o), .oe_n_o(oe_n_o),
    .we_n_o(we_n_o), .byte_lane_select_n_o(byte_lane_select_n_o), .addr_o(addr_o),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o));
  smct_sram_model i_mem (.clock_i(clock_i), .slow_i(slow), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o),
    .we_n_i(we_n_o), .bls_n_i(byte_lane_select_n_o), .addr_i(addr_o[3:0]),
    .wdata_i(data_o), .rdata_o(data_i));
  // Bus clock, 50 ns
  initial
  begin
    forever #25 clock_i = ~clock_i;
  end
  // Hang guard; the run needs about 150 cycles
  always @(posedge clock_i)
  begin
    n_cyc++;
    if (n_cyc == 2000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // One access; counts low cycles of each strobe until completion
  task automatic acc(input logic wr, input logic [23:0] a, input logic [15:0] dat,
    input logic [1:0] ln, output logic [15:0] q, output int ncs, noe, nwe, nln);
    {ncs, noe, nwe, nln} = 128'h0;
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = dat;
    req_lanes_i = ln;
    @(posedge clock_i);
    #1 req_valid_i = 1'b0;
    chk("busy", 0, req_ready_o);
    for (int k = 0; k < 40 && rsp_valid_o !== 1'b1; k++)
    begin
      ncs += int'(cs_n_o === 1'b0);
      noe += int'(oe_n_o === 1'b0);
      nwe += int'(we_n_o === 1'b0);
      nln += int'(byte_lane_select_n_o !== 2'h3);
      @(posedge clock_i);
      #1;
    end
    q = rsp_rdata_o;
    chk("done", 1, rsp_valid_o);
  endtask
  // Pins quiet once out of reset
  task automatic t_reset();
    @(posedge clock_i);
    #1;
    chk("idle pins", 6'h3E, {cs_n_o, oe_n_o, we_n_o, byte_lane_select_n_o, data_oe_o});
    chk("idle ready", 1, req_ready_o);
    $display("test reset done");
  endtask
  // Write and read back over zero, plain, inverted and clipped settings
  task automatic t_timing();
    logic [19:0] cf [5] = '{20'h00000, 20'h25140, 20'h31210, 20'h24031, 20'h443F1};
    logic [15:0] q;
    int ncs, noe, nwe, nln, o, r, e, b, d, w, s;
    for (int i = 0; i < 5; i++)
    begin
      {oe_delay_cycles_i, read_length_cycles_i, we_delay_cycles_i,
        write_length_cycles_i} = cf[i][19:4];
      read_delay_config_i = {2'h0, cf[i][0], 5'h0};
      slow = i == 1;
      o = int'(cf[i][19:16]);
      r = int'(cf[i][15:12]);
      e = int'(cf[i][11:8]);
      b = int'(cf[i][0]);
      d = r < o ? 0 : (o + b > r ? r : o + b);
      w = r < o || r < o + b ? 1 : r - o + 1 - b;
      s = (int'(cf[i][7:4]) < e ? e : int'(cf[i][7:4])) - e + 1;
      acc(1'b1, 24'(i), 16'hA5C3 ^ 16'(i), 2'h3, q, ncs, noe, nwe, nln);
      chk("wr cs", e + s + 2, ncs);
      chk("wr we", s, nwe);
      chk("wr lanes", s + 2, nln);
      acc(1'b0, 24'(i), 16'h0, 2'h3, q, ncs, noe, nwe, nln);
      chk("rd cs", d + w, ncs);
      chk("rd oe", w, noe);
      chk("rd lanes", w, nln);
      chk("rd data", 16'hA5C3 ^ 16'(i), q);
    end
    $display("test timing done");
  endtask
  // A one-lane write leaves the other byte alone
  task automatic t_lanes();
    logic [15:0] q;
    int n0, n1, n2, n3;
    acc(1'b1, 24'h7, 16'hABCD, 2'h3, q, n0, n1, n2, n3);
    acc(1'b1, 24'h7, 16'h1234, 2'h2, q, n0, n1, n2, n3);
    acc(1'b0, 24'h7, 16'h0, 2'h3, q, n0, n1, n2, n3);
    chk("merged", 16'h12CD, q);
    chk("bus free", 0, data_oe_o);
    $display("test lanes done");
  endtask
  // Reset in mid write leaves every strobe off and the bus free after two edges in reset
  task automatic t_abort();
    req_valid_i = 1'b1;
    req_write_i = 1'b1;
    @(posedge clock_i);
    #1 req_valid_i = 1'b0;
    @(posedge clock_i);
    #1 rst_n_i = 1'b0;
    chk("cs mid", 0, cs_n_o);
    repeat (2) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    chk("abort pins", 6'h3E, {cs_n_o, oe_n_o, we_n_o, byte_lane_select_n_o, data_oe_o});
    chk("abort ready", 1, req_ready_o);
    // Next request only after one edge with reset released
    @(posedge clock_i);
    #1;
    $display("test abort done");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Reset for 16 cycles, then run the scenarios
  initial
  begin
    {req_valid_i, req_write_i, req_lanes_i} = 4'h0;
    req_addr_i = 24'h0;
    req_wdata_i = 16'h0;
    {oe_delay_cycles_i, read_length_cycles_i, we_delay_cycles_i,
      write_length_cycles_i} = 16'h0;
    read_delay_config_i = 8'h0;
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    t_reset();
    t_timing();
    t_abort();
    t_lanes();
    tally_and_finish();
  end
endmodule
bind smct_ctrl smct_ctrl_assertions i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .oe_delay_cycles_i(oe_delay_cycles_i), .read_length_cycles_i(read_length_cycles_i),
  .we_delay_cycles_i(we_delay_cycles_i), .write_length_cycles_i(write_length_cycles_i),
  .read_delay_config_i(read_delay_config_i), .req_ready_o(req_ready_o), .cs_n_o(cs_n_o),
  .oe_n_o(oe_n_o), .we_n_o(we_n_o), .byte_lane_select_n_o(byte_lane_select_n_o),
  .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o));
`default_nettype wire
